// ### src/abg_consts.svh
// constants of the two-branch actuator bus gateway: offsets, fields, reset values, timing
`ifndef ABG_CONSTS_SVH
`define ABG_CONSTS_SVH
// register byte offsets
`define ABG_OFS_CTRL 8'h00
`define ABG_OFS_STATUS 8'h04
`define ABG_OFS_IRQ_ST 8'h08
`define ABG_OFS_IRQ_MASK 8'h0C
`define ABG_OFS_LEDS 8'h10
// control register fields
`define ABG_CTRL_SINGLE 0
`define ABG_CTRL_CH1B 1
`define ABG_CTRL_OFF_A 2
`define ABG_CTRL_OFF_B 3
`define ABG_CTRL_W 4
`define ABG_CTRL_RST 4'h0
// irq status fields: pu change a/b, diag done a/b, diag fault a/b
`define ABG_IRQ_PU 0
`define ABG_IRQ_DONE 2
`define ABG_IRQ_FAULT 4
`define ABG_IRQ_W 6
`define ABG_IRQ_RST 6'h00
// branch sizing
`define ABG_NUM_BRANCH 2
`define ABG_MAX_ADDR 4'h8
`define ABG_BURSTS 3'h5
// timing
`define ABG_CLK_HZ 10000000
`define ABG_BIT_RATE 1200
`define ABG_BIT_CYC (`ABG_CLK_HZ / `ABG_BIT_RATE)
`define ABG_CMD_MS 150
`define ABG_CMD_TICKS 11'((`ABG_CMD_MS * `ABG_BIT_RATE) / 1000)
`define ABG_FLASH_MS 200
`define ABG_FLASH_TICKS 11'((`ABG_FLASH_MS * `ABG_BIT_RATE) / 1000)
`define ABG_PAUSE_MS 1000
`define ABG_PAUSE_TICKS 11'((`ABG_PAUSE_MS * `ABG_BIT_RATE) / 1000)
`endif

// ### src/abg_pkg.sv
// types of the two-branch actuator bus gateway
package abg_pkg;
  // per-branch diagnostic sequencer states
  typedef enum logic [1:0] {
    DG_IDLE,
    DG_PROBE,
    DG_WAIT,
    DG_FLASH
  } abg_dg_state_t;

  // per-branch diagnostic state
  typedef struct packed {
    abg_dg_state_t st;
    logic [3:0] addr;
    logic [3:0] faultAddr;
    logic [10:0] cnt;
    logic [3:0] pulse;
    logic [2:0] burst;
    logic led;
  } abg_diag_t;

  // whole state of the gateway
  typedef struct packed {
    logic [13:0] divCnt;
    logic tick;
    logic [3:0] ctrl;
    logic [5:0] irqSt;
    logic [5:0] irqMask;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [1:0] keyPrev;
    logic [1:0] puPrev;
    abg_diag_t [1:0] dg;
    logic [1:0] busOe;
    logic [1:0] busOut;
    logic [1:0] chTxd;
    logic [1:0] puSelect;
    logic puNotify;
    logic [1:0] diagLed;
    logic [6:0] funcLed;
    logic irq;
  } abg_state_t;
endpackage

// ### src/abg_gateway.sv
// two-branch actuator bus gateway with ahb-lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "abg_consts.svh"

module abg_gateway #(
  parameter int unsigned BIT_CYC = `ABG_BIT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // serial channels from the controller, idle high
  input wire logic [1:0] chRxd,
  output logic [1:0] chTxd,
  // actuator branches, open drain, low is active
  input wire logic [1:0] busIn,
  output logic [1:0] busOut,
  output logic [1:0] busOe,
  // parameter setting unit jacks
  input wire logic [1:0] puPlugged,
  output logic [1:0] puSelect,
  output logic puNotify,
  // keys, indicators and interrupt
  input wire logic [1:0] diagKey,
  output logic [1:0] diagLed,
  output logic [6:0] funcLed,
  output logic irq
);
  import abg_pkg::*;

  // all state lives in one packed struct so reset and update stay in one place
  abg_state_t r; // registered state
  abg_state_t nxt; // next state
  logic busy; // decoded address phase
  logic [1:0] served; // branch is connected to a channel
  logic [1:0] srcCh; // channel that serves each branch
  logic [1:0] drvLow; // branch pulled low in the next cycle
  logic [5:0] irqSet; // event pulses
  logic [5:0] irqClr; // write-one-to-clear bits
  logic [10:0] lim; // flash phase length in ticks
  logic [1:0] chBr; // branch that each channel reaches
  logic [31:0] rd; // read mux

  // next state of the whole block
  always_comb
  begin
    nxt = r;
    irqSet = '0;
    irqClr = '0;
    served = '0;
    srcCh = '0;
    drvLow = '0;
    lim = `ABG_FLASH_TICKS;
    rd = '0;
    chBr = '0;
    // hsize is not decoded: every register is one whole word
    busy = hsel && hready && htrans[1];
    // bit rate divider, one tick per signalling pulse
    // the divider restarts at reset, so the first tick comes BIT_CYC cycles after release
    if (32'(r.divCnt) >= BIT_CYC - 1)
    begin
      nxt.divCnt = '0;
      nxt.tick = 1'b1;
    end
    else
    begin
      nxt.divCnt = r.divCnt + 14'h0001;
      nxt.tick = 1'b0;
    end
    // branch routing and diagnostic sequencers
    for (int b = 0; b < `ABG_NUM_BRANCH; b++)
    begin
      // channel 1 takes branch b when swap matches, otherwise channel 2
      srcCh[b] = (b[0] == r.ctrl[`ABG_CTRL_CH1B]) ? 1'b0 : 1'b1;
      // in single mode only channel 1 exists and serves one branch at a time
      served[b] = !r.ctrl[`ABG_CTRL_SINGLE] || !srcCh[b];
      if (r.ctrl[`ABG_CTRL_OFF_A + b] || puPlugged[b])
        drvLow[b] = 1'b0; // off branch or unit plugged: hands off
      else if (r.dg[b].st != DG_IDLE && r.dg[b].st != DG_FLASH)
        drvLow[b] = r.dg[b].st == DG_PROBE; // diagnosis owns the branch
      else
        drvLow[b] = served[b] && !chRxd[srcCh[b]]; // instruction forwarded
      // open drain: only the enable moves, the data level stays low
      nxt.busOe[b] = drvLow[b];
      nxt.busOut[b] = 1'b0;
      // the unit gets the wire as soon as its plug is seen; no debounce is done here
      nxt.puSelect[b] = puPlugged[b];
      if (puPlugged[b] != r.puPrev[b])
        irqSet[`ABG_IRQ_PU + b] = 1'b1; // controller learns of the takeover
      // diagnostic sequencer
      case (r.dg[b].st)
        DG_IDLE:
        begin
          // only a rising key edge on a live branch starts a test
          if (diagKey[b] && !r.keyPrev[b] && !r.ctrl[`ABG_CTRL_OFF_A + b] && !puPlugged[b])
          begin
            nxt.dg[b].st = DG_PROBE;
            nxt.dg[b].addr = 4'h1;
            nxt.dg[b].cnt = '0;
          end
        end
        DG_PROBE:
        begin
          // one signalling pulse low addresses the next actuator
          // limitation: the pulse ends at the next divider tick, so it lasts 1 to BIT_CYC cycles
          if (r.tick)
          begin
            nxt.dg[b].st = DG_WAIT;
            nxt.dg[b].cnt = '0;
            nxt.dg[b].pulse = '0; // reused as answer-seen flag while waiting
          end
        end
        DG_WAIT:
        begin
          // our own probe is still on the wire for one cycle: its low level is no answer
          if (!busIn[b] && !r.busOe[b])
            nxt.dg[b].pulse = 4'h1; // answer started, wait for the slave to release the wire
          // probing again while the answer still pulls low would hide the probe from the slave
          else if (busIn[b] && r.dg[b].pulse != 4'h0)
          begin
            if (r.dg[b].addr == `ABG_MAX_ADDR)
            begin
              nxt.dg[b].st = DG_IDLE;
              irqSet[`ABG_IRQ_DONE + b] = 1'b1;
            end
            else
            begin
              nxt.dg[b].st = DG_PROBE;
              nxt.dg[b].addr = r.dg[b].addr + 4'h1;
            end
          end
          else if (r.tick)
          begin
            // no answer within one command time counts as a fault
            if (r.dg[b].cnt == `ABG_CMD_TICKS - 11'h001)
            begin
              nxt.dg[b].st = DG_FLASH;
              nxt.dg[b].faultAddr = r.dg[b].addr;
              nxt.dg[b].cnt = '0;
              nxt.dg[b].pulse = '0;
              nxt.dg[b].burst = '0;
              nxt.dg[b].led = 1'b1;
              irqSet[`ABG_IRQ_FAULT + b] = 1'b1;
            end
            else
              nxt.dg[b].cnt = r.dg[b].cnt + 11'h001;
          end
        end
        DG_FLASH:
        begin
          // off phase after the last pulse of a burst is the long pause
          if (!r.dg[b].led && r.dg[b].pulse == r.dg[b].faultAddr)
            lim = `ABG_PAUSE_TICKS;
          else
            lim = `ABG_FLASH_TICKS;
          if (r.tick)
          begin
            if (r.dg[b].cnt == lim - 11'h001)
            begin
              nxt.dg[b].cnt = '0;
              if (r.dg[b].led)
              begin
                nxt.dg[b].led = 1'b0;
                nxt.dg[b].pulse = r.dg[b].pulse + 4'h1;
              end
              else if (r.dg[b].pulse == r.dg[b].faultAddr)
              begin
                nxt.dg[b].pulse = '0;
                nxt.dg[b].burst = r.dg[b].burst + 3'h1;
                if (r.dg[b].burst + 3'h1 == `ABG_BURSTS)
                begin
                  nxt.dg[b].st = DG_IDLE;
                  irqSet[`ABG_IRQ_DONE + b] = 1'b1;
                end
                else
                  nxt.dg[b].led = 1'b1;
              end
              else
                nxt.dg[b].led = 1'b1;
            end
            else
              nxt.dg[b].cnt = r.dg[b].cnt + 11'h001;
          end
        end
        default:
          nxt.dg[b].st = DG_IDLE;
      endcase
      nxt.diagLed[b] = nxt.dg[b].st == DG_FLASH && nxt.dg[b].led;
    end
    // answers return on the channel that carried the instruction
    for (int c = 0; c < `ABG_NUM_BRANCH; c++)
    begin
      chBr[c] = c[0] ^ r.ctrl[`ABG_CTRL_CH1B];
      // a branch under test or handed to the setting unit answers nothing
      if (c == 1 && r.ctrl[`ABG_CTRL_SINGLE])
        nxt.chTxd[c] = 1'b1; // no second channel in single mode
      else if (r.ctrl[`ABG_CTRL_OFF_A + chBr[c]] || puPlugged[chBr[c]] || r.dg[chBr[c]].st != DG_IDLE)
        nxt.chTxd[c] = 1'b1; // branch not available to the controller
      else
        nxt.chTxd[c] = busIn[chBr[c]];
    end
    // previous levels for edge detection; reset to the idle levels, so no false edge
    nxt.keyPrev = diagKey;
    nxt.puPrev = puPlugged;
    nxt.puNotify = |puPlugged;
    // indicators are registered with the drive they report, so they light with the pin
    // function indicators
    nxt.funcLed[0] = r.ctrl[`ABG_CTRL_CH1B];
    nxt.funcLed[1] = r.ctrl[`ABG_CTRL_OFF_A];
    nxt.funcLed[4] = r.ctrl[`ABG_CTRL_OFF_B];
    nxt.funcLed[2] = drvLow[0];
    nxt.funcLed[5] = drvLow[1];
    nxt.funcLed[3] = drvLow[0] || !busIn[0];
    nxt.funcLed[6] = drvLow[1] || !busIn[1];
    // hwdata is taken one cycle after its address was accepted
    // write data phase of a previously accepted write
    if (r.wrPend)
    begin
      if (r.wrAddr == `ABG_OFS_CTRL)
        nxt.ctrl = hwdata[`ABG_CTRL_W-1:0];
      else if (r.wrAddr == `ABG_OFS_IRQ_ST)
        irqClr = hwdata[`ABG_IRQ_W-1:0];
      else if (r.wrAddr == `ABG_OFS_IRQ_MASK)
        nxt.irqMask = hwdata[`ABG_IRQ_W-1:0];
    end
    // an event in the clearing cycle survives the clear
    nxt.irqSt = (r.irqSt & ~irqClr) | irqSet;
    // level interrupt taken from the next state, so it drops with the clearing write
    nxt.irq = |(nxt.irqSt & nxt.irqMask);
    // address phase: reads answer in the next cycle, zero when unmapped
    nxt.wrPend = busy && hwrite;
    nxt.wrAddr = haddr[7:0];
    if (busy && !hwrite)
    begin
      if (haddr[7:0] == `ABG_OFS_CTRL)
        rd = {28'h0000000, r.ctrl};
      else if (haddr[7:0] == `ABG_OFS_STATUS)
        rd = {16'h0000, r.dg[1].faultAddr, r.dg[0].faultAddr, 2'h0, served, r.dg[1].st != DG_IDLE,
              r.dg[0].st != DG_IDLE, puPlugged};
      else if (haddr[7:0] == `ABG_OFS_IRQ_ST)
        rd = {26'h0, r.irqSt};
      else if (haddr[7:0] == `ABG_OFS_IRQ_MASK)
        rd = {26'h0, r.irqMask};
      else if (haddr[7:0] == `ABG_OFS_LEDS)
        rd = {23'h0, r.diagLed, r.funcLed};
      else
        rd = '0;
    end
    nxt.hrdata = rd;
    nxt.hreadyout = 1'b1; // zero wait states, slave never stalls
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.ctrl <= `ABG_CTRL_RST;
      r.irqSt <= `ABG_IRQ_RST;
      // channel lines idle high so the controller sees no false start bit
      r.chTxd <= 2'h3;
      r.hreadyout <= 1'b1;
    end
    else
      r <= nxt;
  end

  // ports straight from the state register, except hresp, which is tied low
  assign hreadyout = r.hreadyout;
  assign hrdata = r.hrdata;
  // every transfer completes with an okay response
  assign hresp = 1'b0;
  assign chTxd = r.chTxd;
  assign busOut = r.busOut;
  assign busOe = r.busOe;
  assign puSelect = r.puSelect;
  assign puNotify = r.puNotify;
  assign diagLed = r.diagLed;
  assign funcLed = r.funcLed;
  assign irq = r.irq;

  // checks, mostly on branch a; branch b runs the same loop body
  addr_in_range_a: assert property (@(posedge ref_clk) disable iff (rst) r.dg[0].addr <= `ABG_MAX_ADDR)
    else $error("diag address beyond eight");
  tick_spacing_a: assert property (@(posedge ref_clk) disable iff (rst) r.tick |=> !r.tick [*2])
    else $error("bit ticks too close");
  unit_takeover_a: assert property (@(posedge ref_clk) disable iff (rst)
    puPlugged[0] |=> !r.busOe[0] && r.puNotify && r.puSelect[0])
    else $error("branch still driven under setting unit");
  key_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    r.dg[0].st == DG_IDLE && diagKey[0] && !r.keyPrev[0] && !r.ctrl[`ABG_CTRL_OFF_A] && !puPlugged[0]
    |=> r.dg[0].st == DG_PROBE && r.dg[0].addr == 4'h1)
    else $error("diag key did not start test");
  fault_flash_a: assert property (@(posedge ref_clk) disable iff (rst)
    r.dg[0].st == DG_WAIT && $past(r.dg[0].st) == DG_WAIT ##1 r.dg[0].st == DG_FLASH
    |=> r.diagLed[0] && r.irqSt[`ABG_IRQ_FAULT])
    else $error("fault not flashed");
  route_led_a: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 r.funcLed[0] == $past(r.ctrl[`ABG_CTRL_CH1B]))
    else $error("indicator 0 not following routing");
  tx_led_a: assert property (@(posedge ref_clk) disable iff (rst)
    r.dg[0].st == DG_PROBE && !r.ctrl[`ABG_CTRL_OFF_A] && !puPlugged[0] |=> r.funcLed[2] && r.busOe[0])
    else $error("transmit indicator dark during probe");
  single_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    r.ctrl[`ABG_CTRL_SINGLE] |=> r.chTxd[1])
    else $error("second channel active in single mode");
  forward_a: assert property (@(posedge ref_clk) disable iff (rst)
    r.ctrl == 4'h0 && r.dg[0].st == DG_IDLE && !puPlugged[0] && !chRxd[0] |=> r.busOe[0])
    else $error("instruction not forwarded");
  // branch b indicators
  off_led_a: assert property (@(posedge ref_clk) disable iff (rst)
    r.ctrl[`ABG_CTRL_OFF_B] |=> r.funcLed[4])
    else $error("branch b off indicator dark");
  act_led_a: assert property (@(posedge ref_clk) disable iff (rst) !busIn[1] |=> r.funcLed[6])
    else $error("branch b activity indicator dark");
endmodule // abg_gateway

// ### testbench/abg_actuator_model.sv
// behavioural slave actuator sitting on one branch wire
`timescale 1ns/100ps
module abg_actuator_model #(
  parameter int unsigned BIT_CYC = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // branch wire level, high when released
  input wire logic lineLvl,
  output logic pull,
  // bench control: restart count, stay mute at this instruction
  input wire logic rewind,
  input wire logic [3:0] failAt
);
  logic seenLow; // master instruction in progress
  logic [3:0] probeCnt; // instructions seen since rewind
  int unsigned dly; // turnaround before answering
  int unsigned hold; // answer pulse length left
  // answer pulse lasts one bit time, no shorter than a master probe pulse
  assign pull = (hold != 0);
  // answer only after an instruction ended, never unprompted
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      seenLow <= 1'b0;
      probeCnt <= 4'h0;
      dly <= 0;
      hold <= 0;
    end
    else
    begin
      if (rewind)
        probeCnt <= 4'h0;
      if (!pull && !lineLvl)
        seenLow <= 1'b1;
      else if (seenLow && lineLvl)
      begin
        // one instruction gets one answer, unless told to stay mute
        seenLow <= 1'b0;
        probeCnt <= probeCnt + 4'h1;
        if (probeCnt + 4'h1 != failAt)
          dly <= 2 * BIT_CYC;
      end
      if (dly != 0)
        dly <= dly - 1;
      if (dly == 1)
        hold <= BIT_CYC;
      else if (hold != 0)
        hold <= hold - 1;
    end
  end
endmodule // abg_actuator_model

// ### testbench/abg_gateway_tb.sv
// self-checking bench of the two-branch actuator bus gateway
`timescale 1ns/100ps
`include "abg_consts.svh"
module abg_gateway_tb;
  // clock, reset and ahb-lite master side
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, puNotify, irq;
  logic [31:0] hrdata;
  // channels, branches, jacks and keys
  logic [1:0] chRxd = 2'h3;
  logic [1:0] puPlugged = 2'h0;
  logic [1:0] diagKey = 2'h0;
  logic [1:0] rewind = 2'h0;
  logic [3:0] failAtA = 4'h0;
  logic [1:0] chTxd, busOut, busOe, busIn, slvPull, puSelect, diagLed;
  logic [6:0] funcLed;
  // bookkeeping
  int badCount = 0;
  int nChecks = 0;
  int flashCnt = 0;
  logic ledPrev = 1'b0;
  logic [31:0] r;
  always #50 ref_clk = ~ref_clk;
  // open-drain branch wires with pull-up
  assign busIn = ~(busOe | slvPull);
  abg_gateway #(.BIT_CYC(4)) dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .chRxd(chRxd), .chTxd(chTxd),
    .busIn(busIn), .busOut(busOut), .busOe(busOe), .puPlugged(puPlugged), .puSelect(puSelect),
    .puNotify(puNotify), .diagKey(diagKey), .diagLed(diagLed), .funcLed(funcLed), .irq(irq));
  abg_actuator_model #(.BIT_CYC(4)) act_a (.ref_clk(ref_clk), .rst(rst), .lineLvl(busIn[0]),
    .pull(slvPull[0]), .rewind(rewind[0]), .failAt(failAtA));
  abg_actuator_model #(.BIT_CYC(4)) act_b (.ref_clk(ref_clk), .rst(rst), .lineLvl(busIn[1]),
    .pull(slvPull[1]), .rewind(rewind[1]), .failAt(4'h0));
  // counts lit pulses of the branch a indicator
  always @(posedge ref_clk)
  begin
    ledPrev <= diagLed[0];
    if (diagLed[0] === 1'b1 && ledPrev === 1'b0)
      flashCnt++;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer; waits on hready, no cycle count assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // drive both channel lines, then let the design react
  task automatic chan(input logic [1:0] v);
    @(posedge ref_clk);
    chRxd <= v;
    cyc(2);
  endtask
  // waits for an answer bit on a channel, bounded
  task automatic waitTx(input int i);
    int n;
    n = 0;
    while (chTxd[i] !== 1'b0 && n < 60)
    begin
      cyc(1);
      n++;
    end
    chk("chTxd answer", 32'(chTxd[i]), 32'h0);
    cyc(12);
  endtask
  task automatic waitIrq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic tReset;
    chk("busOe idle", 32'(busOe), 32'h0);
    chk("funcLed idle", 32'(funcLed), 32'h0);
    chk("hresp busOut", 32'({hresp, busOut}), 32'h0);
    wr(8'h40, 32'hF);
    bus(1'b0, 8'h40, 32'h0, r);
    chk("unmapped", r, 32'h0);
    bus(1'b0, `ABG_OFS_CTRL, 32'h0, r);
    chk("ctrl", r, 32'h0);
  endtask
  // each channel reaches its own branch and gets its answer back
  task automatic tLink;
    chan(2'b10);
    chk("busOe ch1", 32'(busOe), 32'h1);
    chk("tx led a", 32'(funcLed[3:2]), 32'h3);
    chan(2'b11);
    waitTx(0);
    chan(2'b01);
    chk("busOe ch2", 32'(busOe), 32'h2);
    chk("tx led b", 32'(funcLed[6:5]), 32'h3);
    chan(2'b11);
    waitTx(1);
  endtask
  // crossed routing, branch off, single channel
  task automatic tRoute;
    wr(`ABG_OFS_CTRL, 32'h2);
    chan(2'b10);
    chk("ch1 on b", {funcLed[0], 29'h0, busOe}, 32'h80000002);
    chan(2'b11);
    waitTx(0);
    wr(`ABG_OFS_CTRL, 32'hC);
    chan(2'b00);
    chk("both off", 32'({funcLed[4], funcLed[1], busOe, chTxd}), 32'h33);
    chan(2'b11);
    wr(`ABG_OFS_CTRL, 32'h1);
    chan(2'b10);
    chk("muxed", 32'({busOe, chTxd[1]}), 32'h3);
    chan(2'b11);
    cyc(30); // thirty cycles let the actuator answer end before the next write
    wr(`ABG_OFS_CTRL, 32'h0);
  endtask
  // setting unit takes branch a and raises the change interrupt
  task automatic tPlug;
    wr(`ABG_OFS_IRQ_MASK, 32'h1);
    @(posedge ref_clk);
    puPlugged <= 2'b01;
    cyc(3);
    chk("pu take", 32'({puSelect, puNotify, irq}), 32'h7);
    chan(2'b10);
    chk("pu no drive", 32'(busOe), 32'h0);
    chan(2'b11);
    @(posedge ref_clk);
    puPlugged <= 2'b00;
    cyc(3);
    wr(`ABG_OFS_IRQ_ST, 32'h3F);
    cyc(2);
    chk("irq clear", 32'(irq), 32'h0);
  endtask
  // start diagnosis on one branch, wait for its done interrupt
  task automatic diag(input int b);
    wr(`ABG_OFS_IRQ_ST, 32'h3F);
    wr(`ABG_OFS_IRQ_MASK, 32'(4 << b));
    @(posedge ref_clk);
    rewind <= 2'b11;
    diagKey[b] <= 1'b1;
    @(posedge ref_clk);
    rewind <= 2'b00;
    repeat (2) @(posedge ref_clk);
    diagKey[b] <= 1'b0;
    flashCnt = 0;
    bus(1'b0, `ABG_OFS_STATUS, 32'h0, r);
    chk("busy", 32'(r[2 + b]), 32'h1);
    waitIrq(80000);
    bus(1'b0, `ABG_OFS_IRQ_ST, 32'h0, r);
  endtask
  task automatic tDiag;
    diag(1);
    chk("diag ok", r & 32'h28, 32'h8);
    failAtA <= 4'h2;
    diag(0);
    chk("diag fault", r & 32'h14, 32'h14);
    chk("flashes", 32'(flashCnt), 32'd10);
    bus(1'b0, `ABG_OFS_STATUS, 32'h0, r);
    chk("fault addr", 32'(r[11:8]), 32'h2);
  endtask
  task automatic endSim;
    if (badCount == 0 && nChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(1);
    tReset;
    tLink;
    tRoute;
    tPlug;
    tDiag;
    endSim;
  end
  // cuts a hang well beyond the expected run
  initial
  begin
    repeat (95000) @(posedge ref_clk);
    badCount++;
    endSim;
  end
endmodule // abg_gateway_tb
